// *** vic_top.sv ***
/*
 Vectored interrupt controller: flags, masks, global enable, priority
 pick, pc-push sequencing and vector hand-off to the core, plus an
 AHB-Lite register slave.
 Assumes one clock hclk (25 MHz), the core reporting instruction
 boundaries, instruction retirement and return-from-handler execution on the
 same clock; pins arrive asynchronous and are synchronised here.
*/
// Notes on behaviour
// - eleven sources plus reset, own vectors
// - forward only if source and global enabled
// - vectors 000..00b in fixed source order
// - lower vector address has higher priority
// - reset vector serves pin and watchdog
// - compare A vectors 003, B 004
// - two 8-bit mask registers, general and timer
// - accepting an interrupt clears global enable
// - software re-enable allows nested interrupt
// - return from handler sets global enable
// - vectoring clears that source's flag
// - writing one clears flag, zero keeps
// - disabled source still sets, holds flag, pin change aside
// - held flags served by priority later
// - level external request has no flag
// - status register never saved nor restored
// - pin change needs group enable, no alt
// - serial start needs its own enable
// - four-cycle entry, waits instruction boundary
// - one instruction after return before next
`timescale 1ns/10ps
`default_nettype none
module vic_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic external_request_zero,
   input wire logic [vic_pkg::NDIG-1:0] digital_pin_change_irq,
   input wire logic [vic_pkg::NANA-1:0] analog_pin_change_irq,
   input wire logic [vic_pkg::NDIG-1:0] digital_alt_fn,
   input wire logic [vic_pkg::NANA-1:0] analog_alt_fn,
   input wire logic reset_pin_req,
   input wire logic watchdog_reset,
   input wire logic evt_cmp_a,
   input wire logic evt_cmp_b,
   input wire logic evt_t1_ovf,
   input wire logic evt_t0_ovf,
   input wire logic serial_start_source,
   input wire logic serial_overflow_source,
   input wire logic eeprom_ready_source,
   input wire logic comparator_source,
   input wire logic evt_adc,
   input wire logic instr_boundary,
   input wire logic instr_retired,
   input wire logic return_from_handler_instr,
   output logic irq_entry,
   output logic vector_valid,
   output logic [9:0] vector_addr,
   output logic global_enable
);
   import vic_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // decoding helpers

   // lowest index wins, so lower vector address wins
   function automatic logic [3:0] pick(input logic [NSRC-1:0] req);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction : pick

   function automatic logic [7:0] gen_view(input logic [NSRC-1:0] f);
      logic [7:0] v;
      v = 8'h00;
      v[EXT_BIT] = f[SRC_EXT];
      v[PCF_BIT] = f[SRC_PC];
      return v;
   endfunction : gen_view

   function automatic logic [7:0] tmr_view(input logic [NSRC-1:0] f);
      logic [7:0] v;
      v = 8'h00;
      v[CMPA_BIT] = f[SRC_CMPA];
      v[CMPB_BIT] = f[SRC_CMPB];
      v[T1OV_BIT] = f[SRC_T1OV];
      v[T0OV_BIT] = f[SRC_T0OV];
      return v;
   endfunction : tmr_view

   ////////////////////////////////////////////////////////////////////
   // state

   vic_regs_t r_reg;
   vic_regs_t r_next;

   logic [NDIG+NANA+1:0] pins_in;
   assign pins_in = {reset_pin_req, external_request_zero,
                     analog_pin_change_irq, digital_pin_change_irq};

   localparam int EXT_PIN = NDIG + NANA;
   localparam int RST_PIN = NDIG + NANA + 1;

   logic [NSRC-1:0] set_ev;
   logic [NSRC-1:0] en;
   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] sw_clr;
   logic [NSRC-1:0] hw_clr;
   logic [NDIG+NANA+1:0] rise;
   logic [NDIG+NANA+1:0] chg;
   logic level_mode;
   logic level_req;
   logic addr_ph;
   logic wr_ph;
   logic [7:0] wb;
   logic [3:0] win;
   logic take;
   logic take_rst;
   logic take_ok;
   logic [NSRC-1:0] clr;

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      r_next = r_reg;
      r_next.vec_valid = 1'b0;
      r_next.readyout = 1'b1;
      // synchronisers; s1 feeds only s2
      r_next.s1 = pins_in;
      r_next.s2 = r_reg.s1;
      r_next.prev = r_reg.s2;
      chg = r_reg.s2 ^ r_reg.prev;
      rise = r_reg.s2 & ~r_reg.prev;

      // event capture, independent of enables except the pin change groups
      level_mode = r_reg.sense == SENSE_LOW;
      set_ev = '0;
      unique case (r_reg.sense)
         SENSE_ANY: begin
            set_ev[SRC_EXT] = chg[EXT_PIN];
         end
         SENSE_FALL: begin
            set_ev[SRC_EXT] = chg[EXT_PIN] & ~r_reg.s2[EXT_PIN];
         end
         SENSE_RISE: begin
            set_ev[SRC_EXT] = rise[EXT_PIN];
         end
         SENSE_LOW: begin
            set_ev[SRC_EXT] = 1'b0;
         end
      endcase
      // group enables mask the flag itself; alt function masks a pin
      set_ev[SRC_PC] =
         (|(chg[NDIG-1:0] & ~digital_alt_fn) & r_reg.gen_mask[PC0_BIT])
         | (|(chg[NDIG+NANA-1:NDIG] & ~analog_alt_fn)
            & r_reg.gen_mask[PC1_BIT]);
      set_ev[SRC_CMPA] = evt_cmp_a;
      set_ev[SRC_CMPB] = evt_cmp_b;
      set_ev[SRC_T1OV] = evt_t1_ovf;
      set_ev[SRC_T0OV] = evt_t0_ovf;
      set_ev[SRC_AUX+0] = serial_start_source;
      set_ev[SRC_AUX+1] = serial_overflow_source;
      set_ev[SRC_AUX+2] = eeprom_ready_source;
      set_ev[SRC_AUX+3] = comparator_source;
      set_ev[SRC_AUX+4] = evt_adc;

      // individual enables, two 8-bit masks plus peripheral copies
      en = '0;
      en[SRC_EXT] = r_reg.gen_mask[EXT_BIT];
      en[SRC_PC] = r_reg.gen_mask[PC0_BIT] | r_reg.gen_mask[PC1_BIT];
      en[SRC_CMPA] = r_reg.tmr_mask[CMPA_BIT];
      en[SRC_CMPB] = r_reg.tmr_mask[CMPB_BIT];
      en[SRC_T1OV] = r_reg.tmr_mask[T1OV_BIT];
      en[SRC_T0OV] = r_reg.tmr_mask[T0OV_BIT];
      // bit 0 mirrors serial_start_irq_enable
      en[SRC_AUX +: NAUX] = r_reg.aux_mask;

      // level request lives only while the pin stays low
      level_req = level_mode & ~r_reg.s2[EXT_PIN];
      // enables gate the request only, not the flag save for pin change, so a source
      // masked now is still served once its enable comes back
      pend = r_reg.flag & en;
      pend[SRC_EXT] = (r_reg.flag[SRC_EXT] | level_req) & en[SRC_EXT];
      pend = pend & {NSRC{r_reg.gie}};
      win = pick(pend);

      // no accept beside a return: the return would reopen the
      // global enable and skip the one-instruction gap
      take_ok = r_reg.st == VIC_IDLE && instr_boundary
                && !return_from_handler_instr;
      // reset vector ignores the global enable
      take_rst = take_ok && r_reg.rst_flag;
      take = take_ok && (|pend || r_reg.rst_flag);

      ////////////////////////////////////////////////////////////////
      // bus: address phase registered, data phase acts
      // zero wait states: hreadyout never drops, so the data phase
      // is always the cycle right after the address phase
      addr_ph = hsel && htrans[1] && hready;
      wr_ph = r_reg.sel_q && r_reg.wr_q;
      wb = hwdata[7:0];
      sw_clr = '0;
      if (wr_ph) begin
         unique case (r_reg.addr_q)
            GEN_MASK_OFS: begin
               r_next.gen_mask = wb & 8'h70;
            end
            TMR_MASK_OFS: begin
               r_next.tmr_mask = wb & 8'h66;
            end
            GEN_FLAG_OFS: begin
               sw_clr[SRC_EXT] = wb[EXT_BIT];
               sw_clr[SRC_PC] = wb[PCF_BIT];
            end
            TMR_FLAG_OFS: begin
               sw_clr[SRC_CMPA] = wb[CMPA_BIT];
               sw_clr[SRC_CMPB] = wb[CMPB_BIT];
               sw_clr[SRC_T1OV] = wb[T1OV_BIT];
               sw_clr[SRC_T0OV] = wb[T0OV_BIT];
            end
            AUX_FLAG_OFS: begin
               sw_clr[SRC_AUX +: NAUX] = wb[NAUX-1:0];
            end
            AUX_MASK_OFS: begin
               r_next.aux_mask = wb[NAUX-1:0];
            end
            EXT_CTRL_OFS: begin
               r_next.sense = wb[1:0];
            end
            // only the global enable is held; status is never stacked
            STATUS_OFS: begin
               r_next.gie = wb[GIE_BIT];
            end
            default: begin
            end
         endcase
      end

      r_next.sel_q = addr_ph;
      r_next.wr_q = hwrite;
      r_next.addr_q = haddr[7:0];
      // read data is the state at the address phase edge; a write
      // landing in that same cycle shows only on the next read
      if (addr_ph && !hwrite) begin
         unique case (haddr[7:0])
            GEN_MASK_OFS: begin
               r_next.rdata = {24'h0, r_reg.gen_mask};
            end
            GEN_FLAG_OFS: begin
               r_next.rdata = {24'h0, gen_view(r_reg.flag)};
            end
            TMR_MASK_OFS: begin
               r_next.rdata = {24'h0, r_reg.tmr_mask};
            end
            TMR_FLAG_OFS: begin
               r_next.rdata = {24'h0, tmr_view(r_reg.flag)};
            end
            STATUS_OFS: begin
               r_next.rdata = {24'h0, r_reg.gie, 7'h00};
            end
            AUX_FLAG_OFS: begin
               r_next.rdata = {27'h0, r_reg.flag[SRC_AUX +: NAUX]};
            end
            AUX_MASK_OFS: begin
               r_next.rdata = {27'h0, r_reg.aux_mask};
            end
            EXT_CTRL_OFS: begin
               r_next.rdata = {30'h0, r_reg.sense};
            end
            VEC_STATE_OFS: begin
               r_next.rdata = {20'h0, r_reg.st, r_reg.vec};
            end
            default: begin
               r_next.rdata = 32'h0;
            end
         endcase
      end

      ////////////////////////////////////////////////////////////////
      // sequencer
      hw_clr = '0;
      unique case (r_reg.st)
         VIC_IDLE: begin
            if (take) begin
               r_next.st = VIC_ENTRY;
               r_next.cnt = ENTRY_LAST;
               r_next.entry = 1'b1;
               r_next.gie = 1'b0;
               if (take_rst) begin
                  r_next.vec = RESET_VECTOR;
               end else begin
                  r_next.vec = 10'(win) + 10'h001;
                  hw_clr[win] = 1'b1;
               end
            end
         end
         VIC_ENTRY: begin
            // pc is pushed by the core during these cycles
            if (r_reg.cnt == 2'h0) begin
               r_next.st = VIC_IDLE;
               r_next.entry = 1'b0;
               r_next.vec_valid = 1'b1;
            end else begin
               r_next.cnt = r_reg.cnt - 2'h1;
            end
         end
         VIC_AFTER_RET: begin
            // one main-program instruction must retire first
            if (instr_retired) begin
               r_next.st = VIC_IDLE;
            end
         end
         default: begin
            r_next.st = VIC_IDLE;
         end
      endcase
      if (return_from_handler_instr) begin
         r_next.gie = 1'b1;
         if (r_reg.st == VIC_IDLE) begin
            r_next.st = VIC_AFTER_RET;
         end
      end

      // set wins over any clear landing in the same cycle
      clr = sw_clr | hw_clr;
      r_next.flag = (r_reg.flag & ~clr) | set_ev;
      if (level_mode) begin
         r_next.flag[SRC_EXT] = 1'b0;
      end
      r_next.rst_flag = (r_reg.rst_flag & ~take_rst)
                        | rise[RST_PIN] | watchdog_reset;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
         r_reg.st <= VIC_IDLE;
         r_reg.gen_mask <= MASK_RST;
         r_reg.tmr_mask <= MASK_RST;
         r_reg.sense <= SENSE_RST;
         r_reg.readyout <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs straight from the state register

   assign hrdata = r_reg.rdata;
   assign hreadyout = r_reg.readyout;
   // every access, mapped or not, answers OKAY
   assign hresp = 1'b0 & r_reg.readyout;
   assign irq_entry = r_reg.entry;
   assign vector_valid = r_reg.vec_valid;
   assign vector_addr = r_reg.vec;
   assign global_enable = r_reg.gie;
endmodule : vic_top
`default_nettype wire

// *** vic_pkg.sv ***
/*
 Shared constants and types of the vectored interrupt controller:
 register offsets, field positions, reset values, source order, timing.
 Assumes a 32-bit AHB-Lite bus with word-aligned registers.
*/
package vic_pkg;
   // register byte offsets
   localparam logic [7:0] GEN_MASK_OFS = 8'h00;
   localparam logic [7:0] GEN_FLAG_OFS = 8'h04;
   localparam logic [7:0] TMR_MASK_OFS = 8'h08;
   localparam logic [7:0] TMR_FLAG_OFS = 8'h0c;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   localparam logic [7:0] AUX_FLAG_OFS = 8'h14;
   localparam logic [7:0] AUX_MASK_OFS = 8'h18;
   localparam logic [7:0] EXT_CTRL_OFS = 8'h1c;
   localparam logic [7:0] VEC_STATE_OFS = 8'h20;

   // general mask / flag bit positions
   localparam int EXT_BIT = 6;
   localparam int PC1_BIT = 5;
   localparam int PC0_BIT = 4;
   localparam int PCF_BIT = 5;
   // timer mask / flag bit positions
   localparam int CMPA_BIT = 6;
   localparam int CMPB_BIT = 5;
   localparam int T1OV_BIT = 2;
   localparam int T0OV_BIT = 1;
   // global enable in processor_status_reg
   localparam int GIE_BIT = 7;

   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [1:0] SENSE_RST = 2'h0;

   // external request sense modes
   localparam logic [1:0] SENSE_LOW = 2'h0;
   localparam logic [1:0] SENSE_ANY = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;

   // source index = vector address - 1, lower index wins
   localparam int NSRC = 11;
   localparam int SRC_EXT = 0;
   localparam int SRC_PC = 1;
   localparam int SRC_CMPA = 2;
   localparam int SRC_CMPB = 3;
   localparam int SRC_T1OV = 4;
   localparam int SRC_T0OV = 5;
   localparam int SRC_AUX = 6;
   localparam int NAUX = 5;
   localparam logic [9:0] RESET_VECTOR = 10'h000;
   localparam logic [9:0] LAST_VECTOR = 10'h00b;

   localparam int NDIG = 4;
   localparam int NANA = 7;

   // interrupt response: pc push cycles before the vector is taken
   localparam logic [2:0] ENTRY_CYCLES = 3'h4;
   localparam logic [1:0] ENTRY_LAST = 2'(ENTRY_CYCLES - 3'h1);

   typedef enum logic [1:0] {
      VIC_IDLE,
      VIC_ENTRY,
      VIC_AFTER_RET
   } vic_state_t;

   typedef struct packed {
      vic_state_t st;
      logic [1:0] cnt;
      logic [9:0] vec;
      logic [7:0] gen_mask;
      logic [7:0] tmr_mask;
      logic [NAUX-1:0] aux_mask;
      logic [1:0] sense;
      logic gie;
      logic [NSRC-1:0] flag;
      logic rst_flag;
      logic [NDIG+NANA+1:0] s1;
      logic [NDIG+NANA+1:0] s2;
      logic [NDIG+NANA+1:0] prev;
      logic sel_q;
      logic wr_q;
      logic [7:0] addr_q;
      logic [31:0] rdata;
      logic readyout;
      logic entry;
      logic vec_valid;
   } vic_regs_t;
endpackage : vic_pkg

// *** vic_chk.sv ***
/*
 Concurrent checks on the core side and bus response of the interrupt controller.
 Sees only vic_top ports; bound in below.
*/
`timescale 1ns/10ps
`default_nettype none
module vic_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic instr_boundary,
   input wire logic return_from_handler_instr,
   input wire logic irq_entry,
   input wire logic vector_valid,
   input wire logic [9:0] vector_addr,
   input wire logic global_enable
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////
   a_entry_clr_gie: assert property ($rose(irq_entry) |-> !global_enable)
      else $error("gie set during entry");
   a_entry_four: assert property ($rose(irq_entry) |->
      irq_entry[*4] ##1 (!irq_entry && vector_valid))
      else $error("entry window not four cycles");
   a_vec_range: assert property (vector_valid |-> vector_addr <= 10'h00b)
      else $error("vector beyond table");
   a_ret_sets_gie: assert property (return_from_handler_instr |=>
      (global_enable || irq_entry))
      else $error("return did not set gie");
   a_take_boundary: assert property ($rose(irq_entry) |->
      $past(instr_boundary))
      else $error("taken off a boundary");
   a_gie_gates: assert property (($rose(irq_entry) &&
      vector_addr != 10'h000) |-> $past(global_enable))
      else $error("taken with gie clear");
   // gie still low at the return, so no take can sneak in beside it
   a_one_instr: assert property ((return_from_handler_instr &&
      !global_enable) |=> !irq_entry[*2])
      else $error("taken right after return");
   a_vec_stable: assert property ((irq_entry && $past(irq_entry)) |->
      $stable(vector_addr))
      else $error("vector moved in entry");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   cover property ($rose(irq_entry) && vector_addr == 10'h000);
   cover property ($rose(irq_entry) && vector_addr == 10'h001);
   cover property (return_from_handler_instr);
endmodule : vic_chk
bind vic_top vic_chk vic_chk_inst (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .instr_boundary(instr_boundary),
   .return_from_handler_instr(return_from_handler_instr),
   .irq_entry(irq_entry), .vector_valid(vector_valid),
   .vector_addr(vector_addr), .global_enable(global_enable));
`default_nettype wire

// *** vic_core_model.sv ***
/*
 Core stand-in: runs a handler of dly+1 cycles after each vector, then
 returns; retires one instruction a cycle outside handlers.
 Assumes hclk and hresetn of the controller.
*/
`timescale 1ns/10ps
`default_nettype none
module vic_core_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic vector_valid,
   input wire logic hold_op,
   input wire logic [3:0] dly,
   output logic instr_boundary,
   output logic instr_retired,
   output logic return_from_handler_instr
);
   logic busy;
   logic [3:0] cnt;
   // hold_op models a multi-cycle instruction in flight
   assign instr_boundary = !hold_op;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         instr_retired <= 1'b0;
         return_from_handler_instr <= 1'b0;
      end else begin
         return_from_handler_instr <= busy && cnt == 4'h0;
         // no retire in the cycle right after the return either
         instr_retired <= !busy && !return_from_handler_instr;
         if (vector_valid) begin
            busy <= 1'b1;
            cnt <= dly;
         end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
         end else if (busy) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule : vic_core_model
`default_nettype wire

// *** vic_top_test.sv ***
/*
 Self-checking bench of vic_top: AHB-Lite master tasks, core model,
 queue of expected vectors. Assumes vic_pkg offsets and field bits.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; \
   $display("Error %0s exp %0h got %0h", n, e, s); end end
module vic_top_test;
   import vic_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic ext = 1'b1, wdog = 1'b0, hold_op = 1'b0, rpin = 1'b0;
   logic [6:0] apin = 7'h00, aalt = 7'h00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'hd649, hrdata, r;
   logic [1:0] htrans = 2'h0;
   logic [3:0] dpin = 4'h0, dalt = 4'h0, dly = 4'h0;
   logic [8:0] ev = 9'h000;
   logic [9:0] vaddr, v_exp;
   logic hreadyout, hresp, boundary, retired, ret, irq_entry, vv, gie;
   logic [9:0] exp_q[$];
   int n_fail = 0, num_checks = 0, cyc = 0, k;
   vic_top vic_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .external_request_zero(ext),
      .digital_pin_change_irq(dpin), .analog_pin_change_irq(apin),
      .digital_alt_fn(dalt), .analog_alt_fn(aalt), .reset_pin_req(rpin),
      .watchdog_reset(wdog), .evt_cmp_a(ev[0]), .evt_cmp_b(ev[1]),
      .evt_t1_ovf(ev[2]), .evt_t0_ovf(ev[3]), .serial_start_source(ev[4]),
      .serial_overflow_source(ev[5]), .eeprom_ready_source(ev[6]),
      .comparator_source(ev[7]), .evt_adc(ev[8]),
      .instr_boundary(boundary), .instr_retired(retired),
      .return_from_handler_instr(ret), .irq_entry(irq_entry),
      .vector_valid(vv), .vector_addr(vaddr), .global_enable(gie));
   vic_core_model vic_core_model_inst (.hclk(hclk), .hresetn(hresetn),
      .vector_valid(vv), .hold_op(hold_op), .dly(dly),
      .instr_boundary(boundary), .instr_retired(retired),
      .return_from_handler_instr(ret));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   // one single transfer; m pulses events in the data phase
   task automatic ahb(input logic [7:0] a, input logic w,
      input logic [31:0] d, input logic [8:0] m);
      haddr <= {24'h0, a};
      hwrite <= w;
      hsel <= 1'b1;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      ev <= m;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      if (m != 9'h000)
         ev <= 9'h000;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(a, 1'b1, d, 9'h000);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
      ahb(a, 1'b0, 32'h0, 9'h000);
      `CHK(n, e, r)
   endtask : rd
   task automatic pulse(input logic [8:0] m);
      ev <= m;
      @(posedge hclk);
      ev <= 9'h000;
   endtask : pulse
   task automatic wait_q;
      while (exp_q.size() != 0) @(posedge hclk);
   endtask : wait_q
   task automatic wait_gie;
      while (gie !== 1'b1) @(posedge hclk);
   endtask : wait_gie
   task automatic note(string s);
      $display("test %0s done", s);
   endtask : note
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #20 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   // every vector handed out must be the next one the model expects
   always @(posedge hclk) begin
      if (vv === 1'b1) begin
         seed <= lfsr(seed);
         dly <= seed[3:0];
         v_exp = (exp_q.size() == 0) ? 10'h3ff : exp_q.pop_front();
         `CHK("vector", v_exp, vaddr)
      end
   end
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (k = 0; k <= 36; k = k + 4)
         rd(k[7:0], 32'h0, "reset value");
      wr(GEN_MASK_OFS, 32'hff);
      rd(GEN_MASK_OFS, 32'h70, "gen mask");
      note("registers");
      wr(GEN_MASK_OFS, 32'h40);
      wr(EXT_CTRL_OFS, {30'h0, SENSE_RISE});
      wr(TMR_MASK_OFS, 32'h66);
      wr(AUX_MASK_OFS, 32'h1f);
      ext <= 1'b0;
      pulse(9'h1ff);
      ext <= 1'b1;
      repeat (6) @(posedge hclk);
      rd(GEN_FLAG_OFS, 32'h40, "ext flag");
      rd(TMR_FLAG_OFS, 32'h66, "tmr flags");
      rd(AUX_FLAG_OFS, 32'h1f, "aux flags");
      exp_q.push_back(10'h001);
      for (k = 3; k <= 11; k++)
         exp_q.push_back(k[9:0]);
      wr(STATUS_OFS, 32'h80);
      wait_q();
      wait_gie();
      rd(STATUS_OFS, 32'h80, "gie");
      rd(TMR_FLAG_OFS, 32'h0, "tmr cleared");
      rd(AUX_FLAG_OFS, 32'h0, "aux cleared");
      note("priority");
      wr(TMR_MASK_OFS, 32'h0);
      pulse(9'h002);
      repeat (4) @(posedge hclk);
      `CHK("masked entry", 1'b0, irq_entry)
      rd(TMR_FLAG_OFS, 32'h20, "held flag");
      wr(TMR_FLAG_OFS, 32'h0);
      rd(TMR_FLAG_OFS, 32'h20, "zero write");
      ahb(TMR_FLAG_OFS, 1'b1, 32'h20, 9'h002);
      rd(TMR_FLAG_OFS, 32'h20, "set beats clear");
      pulse(9'h002);
      exp_q.push_back(10'h004);
      wr(TMR_MASK_OFS, 32'h20);
      wait_q();
      wr(TMR_FLAG_OFS, 32'h02);
      note("flags");
      wait_gie();
      wr(GEN_MASK_OFS, 32'h10);
      dalt <= 4'h1;
      dpin <= 4'h1;
      repeat (6) @(posedge hclk);
      rd(GEN_FLAG_OFS, 32'h0, "alt fn masked");
      exp_q.push_back(10'h002);
      dpin <= 4'h3;
      wait_q();
      note("pin change");
      wait_gie();
      wr(STATUS_OFS, 32'h0);
      hold_op <= 1'b1;
      wdog <= 1'b1;
      @(posedge hclk);
      wdog <= 1'b0;
      repeat (8) @(posedge hclk);
      `CHK("mid instruction", 1'b0, irq_entry)
      exp_q.push_back(10'h000);
      hold_op <= 1'b0;
      wait_q();
      note("watchdog");
      wait_gie();
      wr(EXT_CTRL_OFS, {30'h0, SENSE_LOW});
      wr(GEN_MASK_OFS, 32'h40);
      exp_q.push_back(10'h001);
      ext <= 1'b0;
      while (irq_entry !== 1'b1) @(posedge hclk);
      ext <= 1'b1;
      wait_q();
      rd(GEN_FLAG_OFS, 32'h0, "level flag");
      note("level");
      wait_gie();
      wr(EXT_CTRL_OFS, {30'h0, SENSE_ANY});
      exp_q.push_back(10'h001);
      exp_q.push_back(10'h001);
      ext <= 1'b0;
      repeat (3) @(posedge hclk);
      ext <= 1'b1;
      wait_q();
      wait_gie();
      wr(EXT_CTRL_OFS, {30'h0, SENSE_FALL});
      exp_q.push_back(10'h001);
      ext <= 1'b0;
      wait_q();
      ext <= 1'b1;
      note("edge modes");
      wait_gie();
      wr(GEN_MASK_OFS, 32'h20);
      aalt <= 7'h01;
      apin <= 7'h01;
      repeat (6) @(posedge hclk);
      rd(GEN_FLAG_OFS, 32'h0, "analog alt masked");
      exp_q.push_back(10'h002);
      apin <= 7'h41;
      wait_q();
      wait_gie();
      wr(STATUS_OFS, 32'h0);
      exp_q.push_back(10'h000);
      rpin <= 1'b1;
      wait_q();
      rpin <= 1'b0;
      note("analog and reset pin");
      end_sim();
   end
endmodule : vic_top_test
`default_nettype wire
